//--- logic/twrx_pkg.sv
// Shared constants, state codes and state records of the two-wire receive sequencer
package twrx_pkg;
  // Register byte addresses
  localparam logic [4:0] A_CTRL = 5'h00;
  localparam logic [4:0] A_STAT = 5'h04;
  localparam logic [4:0] A_DATA = 5'h08;
  localparam logic [4:0] A_OWN = 5'h0C;
  localparam logic [4:0] A_RATE = 5'h10;
  localparam logic [4:0] A_IST = 5'h14;
  localparam logic [4:0] A_ICLR = 5'h18;
  localparam logic [4:0] A_IEN = 5'h1C;
  // Control register bit positions
  localparam int B_FLAG = 7;
  localparam int B_ACKEN = 6;
  localparam int B_STA = 5;
  localparam int B_STO = 4;
  localparam int B_ENA = 2;
  // Interrupt status bits
  localparam int IRQ_W = 3;
  localparam int I_EVT = 0;
  localparam int I_ARB = 1;
  localparam int I_STOP = 2;
  // Status codes
  localparam logic [7:0] ST_START = 8'h08;
  localparam logic [7:0] ST_RSTART = 8'h10;
  localparam logic [7:0] ST_ARB = 8'h38;
  localparam logic [7:0] ST_RA_ACK = 8'h40;
  localparam logic [7:0] ST_RA_NACK = 8'h48;
  localparam logic [7:0] ST_RD_ACK = 8'h50;
  localparam logic [7:0] ST_RD_NACK = 8'h58;
  localparam logic [7:0] ST_SD_NACK = 8'h88;
  localparam logic [7:0] ST_GD_ACK = 8'h90;
  localparam logic [7:0] ST_GD_NACK = 8'h98;
  localparam logic [7:0] ST_SSTOP = 8'hA0;
  // Values after reset and bit counts
  localparam logic [7:0] RATE_RST = 8'h18;
  localparam logic LINE_IDLE = 1'b1;
  localparam logic [3:0] BC_ACK = 4'h8;
  localparam logic [3:0] BC_END = 4'h9;

  typedef enum logic [2:0] {
    S_IDLE = 3'h0,
    S_START = 3'h1,
    S_ADDR = 3'h3,
    S_MRX = 3'h2,
    S_HOLD = 3'h6,
    S_STOP = 3'h7,
    S_SLV = 3'h5
  } twrx_st_t;

  typedef struct packed {
    logic meta;
    logic sync;
  } twrx_sync_t;

  typedef struct packed {
    twrx_st_t st;
    logic [1:0] ph;
    logic [3:0] bc;
    logic [7:0] sh;
    logic [7:0] dat;
    logic [7:0] code;
    logic [1:0] pre;
    logic [7:0] rate;
    logic [6:0] own_slave_address;
    logic general_call_enable;
    logic ena;
    logic event_flag;
    logic ack_enable;
    logic start_request;
    logic stop_request;
    logic ack_sel;
    logic ack_seen;
    logic own_bus;
    logic busy;
    logic slv_addr;
    logic slv_gc;
    logic scl_oe;
    logic sda_oe;
    logic lo;
    logic [IRQ_W-1:0] ist;
    logic [IRQ_W-1:0] ien;
    logic irq;
    logic [7:0] rdata;
    logic [15:0] divc;
    logic tick;
    logic scl_p;
    logic sda_p;
  } twrx_state_t;
endpackage : twrx_pkg

//--- logic/twrx_seq.sv
// Two-wire master/slave receive sequencer with status codes and register port
// How it works
// - after a repeated start the next address may name any slave, read or write
// - on 0x08, flag release sends the loaded read address and samples acknowledge
// - on 0x10, read or write address is sent; write form hands over to transmitter (none here: after 0x18/0x20 only start or stop follows)
// - on 0x38, bus is released, unaddressed slave; start follows once bus is free
// - on 0x40 a byte is received, acknowledged per ack_enable
// - on 0x48, start, stop, or stop then start; stop_request self-clears after stop
// - on 0x50 software reads data; next byte is acknowledged per ack_enable
// - on 0x58 software reads last byte; then start, stop, or stop then start
// - unaddressed slave recognises own and general-call address only when ack_enable is set
// - on 0x88 or 0x98, unaddressed slave mode; start when bus free if requested
// - on 0x90 next byte received, ack per ack_enable; start request ignored
// - on 0xA0, leave addressed state; recognition and start follow control bits
// - prescaler bits share the status register; codes assume them masked
//
// Implementation choices: strobed register access and the register addresses.
`timescale 1ns/1ps
module twrx_seq #(
  parameter logic [7:0] ST_WA_ACK = 8'h18,
  parameter logic [7:0] ST_WA_NACK = 8'h20,
  parameter logic [7:0] ST_SA_ACK = 8'h60,
  parameter logic [7:0] ST_GA_ACK = 8'h70,
  parameter logic [7:0] ST_SD_ACK = 8'h80,
  parameter logic [7:0] ST_NONE = 8'hF8
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic [4:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  output logic irq
);
  import twrx_pkg::*;

  twrx_state_t q;
  twrx_state_t d;
  logic scl_s;
  logic sda_s;
  logic start_det;
  logic stop_det;
  logic scl_rise;
  logic scl_fall;
  logic clr_wr;
  logic [15:0] div_lim;
  logic ev;
  logic lose;
  logic [7:0] ev_code;

  ////////////////////////////////////////////////////////////////////////////
  // Line synchronisers and bus condition detection

  twrx_sync #(.RST_LVL(LINE_IDLE)) u_scl_sync (
    .mclk(mclk),
    .nrst(nrst),
    .pin(scl_i),
    .sync(scl_s)
  );

  twrx_sync #(.RST_LVL(LINE_IDLE)) u_sda_sync (
    .mclk(mclk),
    .nrst(nrst),
    .pin(sda_i),
    .sync(sda_s)
  );

  assign start_det = q.sda_p & ~sda_s & scl_s & q.scl_p;
  assign stop_det = ~q.sda_p & sda_s & scl_s & q.scl_p;
  assign scl_rise = ~q.scl_p & scl_s;
  assign scl_fall = q.scl_p & ~scl_s;
  assign clr_wr = wr && (addr == A_CTRL) && wdata[B_FLAG];
  // Quarter-bit period scales by four per prescaler step
  assign div_lim = 16'((17'(q.rate) + 17'h1) << {q.pre, 1'b0});

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    d = q;
    ev = 1'b0;
    lose = 1'b0;
    ev_code = q.code;
    d.tick = 1'b0;
    d.rdata = 8'h00;
    d.scl_p = scl_s;
    d.sda_p = sda_s;
    if (q.divc + 16'h1 >= div_lim) begin
      d.divc = 16'h0000;
      d.tick = 1'b1;
    end else begin
      d.divc = q.divc + 16'h1;
    end
    if (start_det) begin
      d.busy = 1'b1;
    end else if (stop_det) begin
      d.busy = 1'b0;
    end

    if (wr) begin
      if (addr == A_CTRL) begin
        if (wdata[B_FLAG]) begin
          d.event_flag = 1'b0;
        end
        d.ack_enable = wdata[B_ACKEN];
        d.start_request = wdata[B_STA];
        d.stop_request = wdata[B_STO];
        d.ena = wdata[B_ENA];
      end else if (addr == A_STAT) begin
        d.pre = wdata[1:0];
      end else if (addr == A_DATA) begin
        d.dat = wdata;
      end else if (addr == A_OWN) begin
        d.own_slave_address = wdata[7:1];
        d.general_call_enable = wdata[0];
      end else if (addr == A_RATE) begin
        d.rate = wdata;
      end else if (addr == A_ICLR) begin
        d.ist = q.ist & ~wdata[IRQ_W-1:0];
      end else if (addr == A_IEN) begin
        d.ien = wdata[IRQ_W-1:0];
      end
    end

    if (rd) begin
      if (addr == A_CTRL) begin
        d.rdata = {q.event_flag, q.ack_enable, q.start_request, q.stop_request,
                   1'b0, q.ena, 2'b00};
      end else if (addr == A_STAT) begin
        d.rdata = {q.code[7:3], 1'b0, q.pre};
      end else if (addr == A_DATA) begin
        d.rdata = q.dat;
      end else if (addr == A_OWN) begin
        d.rdata = {q.own_slave_address, q.general_call_enable};
      end else if (addr == A_RATE) begin
        d.rdata = q.rate;
      end else if (addr == A_IST) begin
        d.rdata = {5'h00, q.ist};
      end else if (addr == A_IEN) begin
        d.rdata = {5'h00, q.ien};
      end
    end

    case (q.st)
      S_IDLE: begin
        // A pending start waits here until the bus is seen free
        if (q.ena && q.start_request && !q.busy) begin
          d.st = S_START;
          d.ph = 2'h0;
        end else if (q.ena && start_det) begin
          d.st = S_SLV;
          d.bc = 4'h0;
          d.slv_addr = 1'b1;
        end
      end
      S_START: begin
        if (q.tick) begin
          case (q.ph)
            2'h0: begin
              d.sda_oe = 1'b0;
              d.ph = 2'h1;
            end
            2'h1: begin
              d.scl_oe = 1'b0;
              if (scl_s) begin
                d.ph = 2'h2;
              end
            end
            2'h2: begin
              d.sda_oe = 1'b1;
              d.ph = 2'h3;
            end
            default: begin
              d.scl_oe = 1'b1;
              d.own_bus = 1'b1;
              ev = 1'b1;
              ev_code = q.own_bus ? ST_RSTART : ST_START;
            end
          endcase
        end
      end
      S_ADDR: begin
        if (q.tick) begin
          case (q.ph)
            2'h0: begin
              d.sda_oe = (q.bc != BC_ACK) && !q.sh[7];
              d.ph = 2'h1;
            end
            2'h1: begin
              d.scl_oe = 1'b0;
              if (scl_s) begin
                d.ph = 2'h2;
              end
            end
            2'h2: begin
              d.ph = 2'h3;
              if (q.bc != BC_ACK && q.sh[7] && !sda_s) begin
                lose = 1'b1;
              end else if (q.bc == BC_ACK) begin
                d.ack_seen = !sda_s;
              end
            end
            default: begin
              d.scl_oe = 1'b1;
              d.ph = 2'h0;
              if (q.bc == BC_ACK) begin
                ev = 1'b1;
                if (q.dat[0]) begin
                  ev_code = q.ack_seen ? ST_RA_ACK : ST_RA_NACK;
                end else begin
                  ev_code = q.ack_seen ? ST_WA_ACK : ST_WA_NACK;
                end
              end else begin
                d.bc = q.bc + 4'h1;
                d.sh = {q.sh[6:0], 1'b0};
              end
            end
          endcase
        end
      end
      S_MRX: begin
        if (q.tick) begin
          case (q.ph)
            2'h0: begin
              d.sda_oe = (q.bc == BC_ACK) && q.ack_sel;
              d.ph = 2'h1;
            end
            2'h1: begin
              d.scl_oe = 1'b0;
              if (scl_s) begin
                d.ph = 2'h2;
              end
            end
            2'h2: begin
              d.ph = 2'h3;
              if (q.bc != BC_ACK) begin
                d.sh = {q.sh[6:0], sda_s};
              end else if (!q.ack_sel && !sda_s) begin
                lose = 1'b1;
              end
            end
            default: begin
              d.scl_oe = 1'b1;
              d.ph = 2'h0;
              if (q.bc == BC_ACK) begin
                d.dat = q.sh;
                ev = 1'b1;
                ev_code = q.ack_sel ? ST_RD_ACK : ST_RD_NACK;
              end else begin
                d.bc = q.bc + 4'h1;
              end
            end
          endcase
        end
      end
      S_STOP: begin
        if (q.tick) begin
          case (q.ph)
            2'h0: begin
              d.scl_oe = 1'b1;
              d.sda_oe = 1'b1;
              d.ph = 2'h1;
            end
            2'h1: begin
              d.scl_oe = 1'b0;
              if (scl_s) begin
                d.ph = 2'h2;
              end
            end
            2'h2: begin
              d.sda_oe = 1'b0;
              d.ph = 2'h3;
            end
            default: begin
              // A start request still set is served from idle once the stop is seen
              d.stop_request = 1'b0;
              d.own_bus = 1'b0;
              d.ist[I_STOP] = 1'b1;
              d.code = ST_NONE;
              d.ph = 2'h0;
              d.st = S_IDLE;
            end
          endcase
        end
      end
      S_SLV: begin
        if (start_det || stop_det) begin
          d.sda_oe = 1'b0;
          if (q.slv_addr) begin
            d.bc = 4'h0;
            if (stop_det) begin
              d.st = S_IDLE;
            end
          end else begin
            ev = 1'b1;
            ev_code = ST_SSTOP;
          end
        end else if (scl_rise && q.bc < BC_ACK) begin
          d.sh = {q.sh[6:0], sda_s};
          d.bc = q.bc + 4'h1;
        end else if (scl_fall && q.bc == BC_ACK) begin
          if (q.slv_addr) begin
            if (q.ack_enable && !q.sh[0] && (q.sh[7:1] == q.own_slave_address
                || (q.sh[7:1] == 7'h00 && q.general_call_enable))) begin
              d.sda_oe = 1'b1;
              d.bc = BC_END;
              d.slv_gc = (q.sh[7:1] == 7'h00) && q.general_call_enable;
            end else begin
              d.st = S_IDLE;
              d.slv_addr = 1'b0;
            end
          end else begin
            d.sda_oe = q.ack_sel;
            d.bc = BC_END;
          end
        end else if (scl_fall && q.bc == BC_END) begin
          // Stretch the clock low until software answers
          d.sda_oe = 1'b0;
          d.scl_oe = 1'b1;
          ev = 1'b1;
          d.slv_addr = 1'b0;
          if (q.slv_addr) begin
            ev_code = q.slv_gc ? ST_GA_ACK : ST_SA_ACK;
          end else begin
            d.dat = q.sh;
            if (q.slv_gc) begin
              ev_code = q.ack_sel ? ST_GD_ACK : ST_GD_NACK;
            end else begin
              ev_code = q.ack_sel ? ST_SD_ACK : ST_SD_NACK;
            end
          end
        end
      end
      S_HOLD: begin
        if (!q.event_flag) begin
          d.ph = 2'h0;
          d.bc = 4'h0;
          d.sh = q.dat;
          if (q.code == ST_START || q.code == ST_RSTART) begin
            d.st = S_ADDR;
          end else if (q.code == ST_RA_ACK || q.code == ST_RD_ACK) begin
            d.st = S_MRX;
            d.ack_sel = q.ack_enable;
          end else if (q.code == ST_SA_ACK || q.code == ST_GA_ACK
                       || q.code == ST_SD_ACK || q.code == ST_GD_ACK) begin
            // Start request plays no part while addressed
            d.st = S_SLV;
            d.ack_sel = q.ack_enable;
            d.scl_oe = 1'b0;
          end else if (q.own_bus) begin
            // With neither request set the bus is closed by a stop
            d.st = (q.start_request && !q.stop_request) ? S_START : S_STOP;
          end else begin
            d.st = S_IDLE;
            d.scl_oe = 1'b0;
            d.sda_oe = 1'b0;
          end
        end
      end
      default: begin
        d.st = S_IDLE;
      end
    endcase

    if (lose) begin
      ev = 1'b1;
      ev_code = ST_ARB;
      d.scl_oe = 1'b0;
      d.sda_oe = 1'b0;
      d.own_bus = 1'b0;
      d.ist[I_ARB] = 1'b1;
    end
    // Hardware set is applied after the clear so it wins
    if (ev) begin
      d.st = S_HOLD;
      d.code = ev_code;
      d.event_flag = 1'b1;
      d.ist[I_EVT] = 1'b1;
      d.ph = 2'h0;
    end
    if (!q.ena) begin
      d.st = S_IDLE;
      d.scl_oe = 1'b0;
      d.sda_oe = 1'b0;
      d.own_bus = 1'b0;
    end
    d.irq = |(q.ist & q.ien);
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      q <= '0;
      q.code <= ST_NONE;
      q.rate <= RATE_RST;
      q.scl_p <= LINE_IDLE;
      q.sda_p <= LINE_IDLE;
    end else begin
      q <= d;
    end
  end

  assign rdata = q.rdata;
  assign irq = q.irq;
  assign scl_oe = q.scl_oe;
  assign sda_oe = q.sda_oe;
  assign scl_o = q.lo;
  assign sda_o = q.lo;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!nrst);

  sequence s_resume;
    q.st == S_HOLD && !q.event_flag && q.ena;
  endsequence

  a_stall_hold: assert property (
    (q.st == S_HOLD && q.event_flag && q.ena && !clr_wr) |=> q.st == S_HOLD)
    else $error("bus action started while event flag still set");
  a_first_addr: assert property (
    (s_resume ##0 q.code == ST_START) |=> (q.st == S_ADDR && q.bc == 4'h0))
    else $error("address not sent after start status");
  a_rstart_addr: assert property (
    (s_resume ##0 q.code == ST_RSTART) |=> (q.st == S_ADDR && q.sh == $past(q.dat)))
    else $error("loaded address not sent after repeated start");
  a_arb_release: assert property (
    (q.st == S_HOLD && q.code == ST_ARB) |-> (!q.scl_oe && !q.sda_oe))
    else $error("bus not released after lost arbitration");
  a_ack_drive: assert property (
    (q.st == S_MRX && q.bc == BC_ACK && q.ph == 2'h2) |-> q.sda_oe == q.ack_sel)
    else $error("acknowledge bit does not follow ack enable");
  a_ack_latched: assert property (
    (s_resume ##0 (q.code == ST_RD_ACK || q.code == ST_RA_ACK))
    |=> (q.st == S_MRX && q.ack_sel == $past(q.ack_enable)))
    else $error("next byte not received with chosen acknowledge");
  a_stop_clears: assert property (
    (q.st == S_STOP && q.ph == 2'h3 && q.tick) |=> (!q.stop_request && q.st == S_IDLE))
    else $error("stop request not cleared after stop");
  a_final_byte: assert property (
    (s_resume ##0 (q.code == ST_RD_NACK && q.stop_request)) |=> q.st == S_STOP)
    else $error("stop not issued after final byte");
  a_recog_gate: assert property (
    (q.st == S_SLV && q.slv_addr && q.bc == BC_ACK && scl_fall && !start_det
     && !stop_det && !q.ack_enable) |=> (!q.sda_oe && q.st == S_IDLE))
    else $error("address recognised with ack enable clear");
  a_gc_continue: assert property (
    (s_resume ##0 q.code == ST_GD_ACK) |=> (q.st == S_SLV && !q.scl_oe))
    else $error("general call byte not resumed");
  a_unaddressed: assert property (
    (s_resume ##0 (q.code == ST_SD_NACK || q.code == ST_GD_NACK || q.code == ST_SSTOP))
    |=> (q.st == S_IDLE && !q.scl_oe && !q.sda_oe))
    else $error("not back to unaddressed slave mode");
  a_status_mask: assert property (
    (rd && addr == A_STAT) |=> q.rdata[2:0] == {1'b0, $past(q.pre)})
    else $error("prescaler bits missing from status read");
endmodule : twrx_seq

//--- logic/twrx_sync.sv
// Two-stage synchroniser for one bus line
`timescale 1ns/1ps
module twrx_sync #(
  parameter logic RST_LVL = twrx_pkg::LINE_IDLE
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic pin,
  output logic sync
);
  import twrx_pkg::*;

  twrx_sync_t q;
  twrx_sync_t d;

  always_comb begin
    d.meta = pin;
    d.sync = q.meta;
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      q <= '{meta: RST_LVL, sync: RST_LVL};
    end else begin
      q <= d;
    end
  end

  assign sync = q.sync;
endmodule : twrx_sync

//--- verification/testbench.sv
// Self-checking bench for the two-wire receive sequencer
`timescale 1ns/1ps
module testbench;
  import twrx_pkg::*;
  logic mclk = 1'b0, nrst = 1'b0, b_wr = 1'b0, b_rd = 1'b0, k1, k2;
  logic [4:0] addr = 5'h00;
  logic [7:0] wdata = 8'h00, v, rdata;
  logic scl_oe, sda_oe, p_scl_oe, p_sda_oe, irq;
  wire logic scl = ~(scl_oe | p_scl_oe);
  wire logic sda = ~(sda_oe | p_sda_oe);
  int err_total = 0, n_checks = 0;
  logic [4:0] ra [9] = '{A_CTRL, A_STAT, A_DATA, A_OWN, A_RATE, A_IST, A_ICLR, A_IEN, 5'h02};
  logic [7:0] rv [9] = '{8'h00, 8'hF8, 8'h00, 8'h00, RATE_RST, 8'h00, 8'h00, 8'h00, 8'h00};
  always #2.5 mclk = ~mclk;
  twrx_seq DUT (.mclk(mclk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(b_wr), .rd(b_rd),
    .rdata(rdata), .scl_i(scl), .scl_o(), .scl_oe(scl_oe), .sda_i(sda), .sda_o(),
    .sda_oe(sda_oe), .irq(irq));
  twrx_peer p (.scl(scl), .sda(sda), .scl_oe(p_scl_oe), .sda_oe(p_sda_oe));
  ////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    n_checks++;
    if (s !== e) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, s, e);
    end
  endtask : chk
  task automatic reg_w(input logic [4:0] a, input logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    b_wr <= 1'b1;
    @(posedge mclk);
    b_wr <= 1'b0;
  endtask : reg_w
  task automatic reg_r(input logic [4:0] a, output logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    b_rd <= 1'b1;
    @(posedge mclk);
    b_rd <= 1'b0;
    #1 d = rdata;
  endtask : reg_r
  // Control word: flag release and enable always set; x = ack, start, stop
  function automatic logic [7:0] cw(input logic [2:0] x);
    return {1'b1, x, 4'h4};
  endfunction : cw
  // Polls the flag under a bound, then compares the masked status
  task automatic wait_ev(input logic [7:0] c);
    v = 8'h00;
    for (int i = 0; i < 3000 && v[B_FLAG] !== 1'b1; i++) reg_r(A_CTRL, v);
    chk(v[B_FLAG], 1'b1);
    reg_r(A_STAT, v);
    chk({v[7:3], 3'h0}, c);
  endtask : wait_ev
  // From a start status: a stop only makes sense once the address and a final byte are through
  task automatic stop_chk();
    reg_w(A_DATA, 8'hA1);
    reg_w(A_CTRL, cw(3'h0));
    wait_ev(ST_RA_ACK);
    reg_w(A_CTRL, cw(3'h0));
    wait_ev(ST_RD_NACK);
    reg_r(A_DATA, v);
    chk(v, 8'h5A);
    reg_w(A_CTRL, cw(3'h1));
    repeat (300) @(posedge mclk);
    reg_r(A_CTRL, v);
    chk(v[B_STO], 1'b0);
    reg_r(A_STAT, v);
    chk({v[7:3], 3'h0}, 8'hF8);
  endtask : stop_chk
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : end_sim
  ////////////////////////////////////////////////////////////////
  task automatic t_regs();
    reg_w(5'h02, 8'hFF);
    reg_w(A_CTRL, 8'h0B);
    for (int i = 0; i < 9; i++) begin
      reg_r(ra[i], v);
      chk(v, rv[i]);
    end
    reg_w(A_STAT, 8'h03);
    reg_r(A_STAT, v);
    chk(v, 8'hFB);
    reg_w(A_STAT, 8'h00);
    $display("register test done");
  endtask : t_regs
  task automatic t_mrx();
    reg_w(A_RATE, 8'h03);
    reg_w(A_IEN, 8'h01);
    reg_w(A_CTRL, cw(3'h2));
    wait_ev(ST_START);
    repeat (40) @(posedge mclk);
    #1 chk(scl_oe, 1'b1);
    chk(irq, 1'b1);
    reg_w(A_IEN, 8'h00);
    repeat (2) @(posedge mclk);
    #1 chk(irq, 1'b0);
    reg_w(A_IEN, 8'h01);
    reg_w(A_ICLR, 8'h01);
    repeat (2) @(posedge mclk);
    #1 chk(irq, 1'b0);
    reg_w(A_DATA, 8'hA1);
    reg_w(A_CTRL, cw(3'h4));
    wait_ev(ST_RA_ACK);
    reg_w(A_CTRL, cw(3'h4));
    wait_ev(ST_RD_ACK);
    reg_r(A_DATA, v);
    chk(v, 8'h5A);
    chk(p.ack_seen, 1'b0);
    reg_w(A_CTRL, cw(3'h0));
    wait_ev(ST_RD_NACK);
    reg_r(A_DATA, v);
    chk(v, 8'hC3);
    chk(p.ack_seen, 1'b1);
    reg_w(A_CTRL, cw(3'h2));
    wait_ev(ST_RSTART);
    // Write form after a repeated start; nobody answers it
    reg_w(A_DATA, 8'hA0);
    reg_w(A_CTRL, cw(3'h0));
    wait_ev(8'h20);
    reg_w(A_CTRL, cw(3'h2));
    wait_ev(ST_RSTART);
    reg_w(A_DATA, 8'hB3);
    reg_w(A_CTRL, cw(3'h0));
    wait_ev(ST_RA_NACK);
    reg_w(A_CTRL, cw(3'h3));
    wait_ev(ST_START);
    reg_r(A_IST, v);
    chk(v[I_STOP], 1'b1);
    $display("master receive test done");
  endtask : t_mrx
  task automatic t_arb();
    reg_w(A_DATA, 8'hA1);
    p.jam = 1'b1;
    reg_w(A_CTRL, cw(3'h0));
    wait_ev(ST_ARB);
    chk({scl_oe, sda_oe}, 8'h00);
    reg_r(A_IST, v);
    chk(v[I_ARB], 1'b1);
    reg_w(A_CTRL, cw(3'h2));
    repeat (100) @(posedge mclk);
    #1 chk(scl_oe, 1'b0);
    p.jam = 1'b0;
    wait_ev(ST_START);
    stop_chk();
    $display("arbitration test done");
  endtask : t_arb
  task automatic t_slv();
    reg_w(A_OWN, 8'h61);
    reg_w(A_CTRL, cw(3'h4));
    fork
      begin
        p.mstart();
        p.mbyte(8'h60, k1);
        p.mbyte(8'h3C, k2);
        p.mstop();
      end
      begin
        wait_ev(8'h60);
        reg_w(A_CTRL, cw(3'h0));
        wait_ev(ST_SD_NACK);
        reg_r(A_DATA, v);
        chk(v, 8'h3C);
        reg_w(A_CTRL, cw(3'h0));
      end
    join
    chk({k1, k2}, 8'h01);
    p.mstart();
    p.mbyte(8'h60, k1);
    p.mstop();
    chk(k1, 1'b1);
    reg_w(A_CTRL, cw(3'h4));
    fork
      begin
        p.mstart();
        p.mbyte(8'h00, k1);
        p.mbyte(8'h77, k2);
        p.mstop();
      end
      begin
        wait_ev(8'h70);
        reg_w(A_CTRL, cw(3'h4));
        wait_ev(ST_GD_ACK);
        reg_r(A_DATA, v);
        chk(v, 8'h77);
        reg_w(A_CTRL, cw(3'h6));
        wait_ev(ST_SSTOP);
      end
    join
    chk({k1, k2}, 8'h00);
    reg_w(A_CTRL, cw(3'h6));
    wait_ev(ST_START);
    stop_chk();
    $display("slave receive test done");
  endtask : t_slv
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge mclk);
    nrst <= 1'b1;
    t_regs();
    t_mrx();
    t_arb();
    t_slv();
    end_sim();
  end
  // Whole run is some tens of microseconds; this bound only cuts a hang
  initial begin
    #400000;
    err_total++;
    end_sim();
  end
endmodule : testbench

//--- verification/twrx_peer.sv
// Behavioural far-side parties on the two-wire bus: a read slave and a write master
`timescale 1ns/1ps
module twrx_peer (
  input wire logic scl,
  input wire logic sda,
  output logic scl_oe,
  output logic sda_oe
);
  localparam realtime Q = 31.25;
  logic s_oe = 1'b0, st = 1'b0, m_scl = 1'b0, m_sda = 1'b0, jam = 1'b0;
  logic ack_seen, bit_in;
  assign scl_oe = m_scl | st;
  assign sda_oe = s_oe | m_sda | jam;
  ////////////////////////////////////////////////////////////////
  // Slave at 0x50 answers reads with 0x5A, then 0xC3, until not acknowledged
  task automatic serve();
    logic [7:0] a, t;
    t = 8'h5A;
    repeat (8) @(posedge scl) a = {a[6:0], sda};
    if (a === 8'hA1) begin
      @(negedge scl) #10 s_oe = 1'b1;
      // One stretch of the clock, so the master must wait for the line
      st = 1'b1;
      #200 st = 1'b0;
      do begin
        for (int i = 7; i >= 0; i--) @(negedge scl) #10 s_oe = ~t[i];
        @(negedge scl) #10 s_oe = 1'b0;
        @(posedge scl) ack_seen = sda;
        t = t ^ 8'h99;
      end while (ack_seen === 1'b0);
    end
  endtask : serve
  // Any start, repeated or not, restarts the slave's byte count
  initial begin
    @(negedge sda iff scl === 1'b1);
    forever begin
      fork
        serve();
      join_none
      @(negedge sda iff scl === 1'b1);
      disable fork;
      s_oe = 1'b0;
      st = 1'b0;
    end
  end
  ////////////////////////////////////////////////////////////////
  // Write master; the clock stands still between frames
  task automatic mbit(input logic b);
    #Q m_sda = ~b;
    #Q m_scl = 1'b0;
    wait (scl === 1'b1);
    #Q bit_in = sda;
    #Q m_scl = 1'b1;
  endtask : mbit
  task automatic mbyte(input logic [7:0] d, output logic k);
    for (int i = 7; i >= 0; i--) mbit(d[i]);
    mbit(1'b1);
    k = bit_in;
  endtask : mbyte
  task automatic mstart();
    m_sda = 1'b1;
    #Q m_scl = 1'b1;
  endtask : mstart
  task automatic mstop();
    #Q m_sda = 1'b1;
    #Q m_scl = 1'b0;
    wait (scl === 1'b1);
    #Q m_sda = 1'b0;
    #Q;
  endtask : mstop
endmodule : twrx_peer
